// file: include/self_diag_pkg.sv
// Constants and types shared by the self-diagnostic supervisor
package self_diag_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] STATUS_REG_ADDR = 16'h007D;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_USED_MASK = 16'h73FF;

  // ************************************************************
  // Fault status bit positions
  // ************************************************************
  localparam int BIT_EXTERNAL_TIMEKEEPER = 0;
  localparam int BIT_INTERNAL_TIMEKEEPER = 1;
  localparam int BIT_SETTINGS_EEPROM = 2;
  localparam int BIT_ANALOG_INPUT_EEPROM = 3;
  localparam int BIT_MRAM = 4;
  localparam int BIT_EMMC = 5;
  localparam int BIT_MAIN_POWER_LOST = 6;
  localparam int BIT_ANALOG_INPUT_ADC = 7;
  localparam int BIT_SUPPLY_OUTPUT_BOARD = 8;
  localparam int BIT_DIGITAL_IO_BOARD = 9;
  localparam int BIT_ANALOG_OUTPUT_BOARD = 12;
  localparam int BIT_REALTIME_MODULE = 13;
  localparam int BIT_BACKGROUND_MODULE = 14;

  // ************************************************************
  // Hardware fault input vector layout
  // ************************************************************
  localparam int HW_FAULT_W = 11;
  localparam int HW_IN_SUPPLY_OUTPUT = 8;
  localparam int HW_IN_DIGITAL_IO = 9;
  localparam int HW_IN_ANALOG_OUTPUT = 10;

  // ************************************************************
  // Output relay layout
  // ************************************************************
  localparam int RELAY_W = 8;
  localparam int READY_RELAY_DO = 5;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int unsigned RECOVERY_TIME_MS = 5000;
  localparam int unsigned RECOVERY_CYCLES = RECOVERY_TIME_MS * CYCLES_PER_MS;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * CYCLES_PER_MS;
  localparam int unsigned HEARTBEAT_TIMEOUT_MS = 100;
  localparam int unsigned HEARTBEAT_CYCLES = HEARTBEAT_TIMEOUT_MS * CYCLES_PER_MS;
  localparam int CNT_W = 28;
  localparam int SW_MODULES = 2;

  // ************************************************************
  // Operating states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_ERROR,
    ST_CONFIRMED
  } op_state_e;

endpackage : self_diag_pkg

// file: rtl/sw_heartbeat_watchdog.sv
// Heartbeat watchdogs for the real-time and background software modules
`timescale 1ns/10ps
module sw_heartbeat_watchdog #(
  parameter int unsigned TIMEOUT_CYCLES = self_diag_pkg::HEARTBEAT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Heartbeat toggles, bit 0 real-time, bit 1 background
  input wire logic [self_diag_pkg::SW_MODULES-1:0] heartbeat_i,
  // Not-responding flags
  output logic [self_diag_pkg::SW_MODULES-1:0] stalled_o
);

  typedef struct packed {
    logic [self_diag_pkg::SW_MODULES-1:0][self_diag_pkg::CNT_W-1:0] cnt;
    logic [self_diag_pkg::SW_MODULES-1:0] hb_prev;
    logic [self_diag_pkg::SW_MODULES-1:0] stalled;
  } wd_s;

  localparam logic [self_diag_pkg::CNT_W-1:0] LIMIT =
    self_diag_pkg::CNT_W'(TIMEOUT_CYCLES - 1);

  wd_s state_reg;
  wd_s state_next;

  // ************************************************************
  // Per-module timeout: any heartbeat edge restarts the count
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < self_diag_pkg::SW_MODULES; i++)
    begin
      state_next.hb_prev[i] = heartbeat_i[i];
      if (heartbeat_i[i] != state_reg.hb_prev[i])
      begin
        state_next.cnt[i] = '0;
        state_next.stalled[i] = 1'b0;
      end
      else if (state_reg.cnt[i] == LIMIT)
      begin
        state_next.stalled[i] = 1'b1;
      end
      else
      begin
        state_next.cnt[i] = state_reg.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign stalled_o = state_reg.stalled;

endmodule : sw_heartbeat_watchdog

// file: rtl/self_diagnostic_monitor.sv
// Self-diagnostic supervisor: fault status register and operating states
//
// Functional notes
// - Keep 16-bit fault status register, master-readable
// - Bit one means fault present now
// - Monitor hardware and software faults continuously
// - Exactly three states: normal, error, confirmed
// - Normal: LED steady, ready relay on
// - Fault enters error; cleared within 5 s returns
// - Error: blink LED, beep, flag, HMI fault
// - Error and confirmed block protection and relays
// - Acknowledge moves error to confirmed, no beep
// - Hardware fault bits 0 to 7 mapped
// - Board faults on bits 8, 9, 12
// - Software module faults on bits 13, 14
// - Watchdog status drives ready relay, DO6 mappable
`timescale 1ns/10ps
module self_diagnostic_monitor #(
  parameter int unsigned RECOVERY_CYCLES = self_diag_pkg::RECOVERY_CYCLES,
  parameter int unsigned BLINK_HALF_CYCLES = self_diag_pkg::BLINK_HALF_CYCLES,
  parameter int unsigned HEARTBEAT_CYCLES = self_diag_pkg::HEARTBEAT_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // Fault indications
  input wire logic [self_diag_pkg::HW_FAULT_W-1:0] HW_FAULT_I,
  input wire logic REALTIME_SOFTWARE_MODULE_HB_I,
  input wire logic BACKGROUND_SOFTWARE_MODULE_HB_I,
  // Operator acknowledge
  input wire logic FAULT_ACK_I,
  // Relay mapping and commands
  input wire logic READY_MAP_DO6_I,
  input wire logic [self_diag_pkg::RELAY_W-1:0] RELAY_CMD_I,
  // Register access
  input wire logic REG_SEL_I,
  input wire logic REG_WE_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_ACK_O,
  output logic REG_EXC_O,
  // Indications
  output logic READY_LED_O,
  output logic READY_RELAY_O,
  output logic BEEPER_O,
  output logic HMI_FAULT_O,
  output logic [1:0] OP_STATE_O,
  output logic [15:0] FAULT_STATUS_O,
  // Protection control
  output logic PROT_BLOCK_O,
  output logic RELAY_BLOCK_O,
  output logic [self_diag_pkg::RELAY_W-1:0] RELAY_O
);

  localparam logic [self_diag_pkg::CNT_W-1:0] RECOVERY_LAST =
    self_diag_pkg::CNT_W'(RECOVERY_CYCLES - 1);
  localparam logic [self_diag_pkg::CNT_W-1:0] BLINK_LAST =
    self_diag_pkg::CNT_W'(BLINK_HALF_CYCLES - 1);

  typedef struct packed {
    self_diag_pkg::op_state_e op_state;
    logic [self_diag_pkg::CNT_W-1:0] recov_cnt;
    logic recov_expired;
    logic [self_diag_pkg::CNT_W-1:0] blink_cnt;
    logic blink;
    logic [15:0] status;
    logic [15:0] rdata;
    logic ack;
    logic exc;
    logic [self_diag_pkg::RELAY_W-1:0] relays;
  } mon_s;

  mon_s state_reg;
  mon_s state_next;
  logic [self_diag_pkg::SW_MODULES-1:0] sw_stalled;
  logic [15:0] status_now;
  logic fault_present;
  logic blocked;
  logic ready;
  logic led_blink_en;
  logic beep;
  logic hmi_fault;

  // ************************************************************
  // Software module watchdogs
  // ************************************************************
  sw_heartbeat_watchdog #(
    .TIMEOUT_CYCLES(HEARTBEAT_CYCLES)
  ) sw_heartbeat_watchdog_i (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .heartbeat_i({BACKGROUND_SOFTWARE_MODULE_HB_I, REALTIME_SOFTWARE_MODULE_HB_I}),
    .stalled_o(sw_stalled)
  );

  // ************************************************************
  // Fault status assembly
  // ************************************************************
  always_comb
  begin
    status_now = 16'h0000;
    status_now[7:0] = HW_FAULT_I[7:0];
    status_now[self_diag_pkg::BIT_SUPPLY_OUTPUT_BOARD] =
      HW_FAULT_I[self_diag_pkg::HW_IN_SUPPLY_OUTPUT];
    status_now[self_diag_pkg::BIT_DIGITAL_IO_BOARD] =
      HW_FAULT_I[self_diag_pkg::HW_IN_DIGITAL_IO];
    status_now[self_diag_pkg::BIT_ANALOG_OUTPUT_BOARD] =
      HW_FAULT_I[self_diag_pkg::HW_IN_ANALOG_OUTPUT];
    status_now[self_diag_pkg::BIT_REALTIME_MODULE] = sw_stalled[0];
    status_now[self_diag_pkg::BIT_BACKGROUND_MODULE] = sw_stalled[1];
    status_now = status_now & self_diag_pkg::STATUS_USED_MASK;
  end

  assign fault_present = |state_reg.status;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    // Live fault picture, refreshed every cycle
    state_next.status = status_now;

    // Blink time base
    if (state_reg.blink_cnt == BLINK_LAST)
    begin
      state_next.blink_cnt = '0;
      state_next.blink = ~state_reg.blink;
    end
    else
    begin
      state_next.blink_cnt = state_reg.blink_cnt + 1'b1;
    end

    // Operating states
    case (state_reg.op_state)
      self_diag_pkg::ST_NORMAL:
      begin
        if (fault_present)
        begin
          state_next.op_state = self_diag_pkg::ST_ERROR;
          state_next.recov_cnt = '0;
          state_next.recov_expired = 1'b0;
        end
      end
      self_diag_pkg::ST_ERROR:
      begin
        if (!fault_present && !state_reg.recov_expired)
        begin
          state_next.op_state = self_diag_pkg::ST_NORMAL;
        end
        else if (FAULT_ACK_I)
        begin
          state_next.op_state = self_diag_pkg::ST_CONFIRMED;
        end
        if (!state_reg.recov_expired)
        begin
          if (state_reg.recov_cnt == RECOVERY_LAST)
          begin
            state_next.recov_expired = 1'b1;
          end
          else
          begin
            state_next.recov_cnt = state_reg.recov_cnt + 1'b1;
          end
        end
      end
      self_diag_pkg::ST_CONFIRMED:
      begin
        if (!fault_present)
        begin
          state_next.op_state = self_diag_pkg::ST_NORMAL;
        end
      end
      default:
      begin
        state_next.op_state = self_diag_pkg::ST_ERROR;
        state_next.recov_cnt = '0;
        state_next.recov_expired = 1'b0;
      end
    endcase

    // Output relays, DO6 optionally carries the ready relay
    for (int i = 0; i < self_diag_pkg::RELAY_W; i++)
    begin
      state_next.relays[i] = RELAY_CMD_I[i] &
        (state_next.op_state == self_diag_pkg::ST_NORMAL);
    end
    if (READY_MAP_DO6_I)
    begin
      state_next.relays[self_diag_pkg::READY_RELAY_DO] =
        (state_next.op_state == self_diag_pkg::ST_NORMAL);
    end

    // Register access, one-cycle answer
    state_next.ack = 1'b0;
    state_next.exc = 1'b0;
    if (REG_SEL_I)
    begin
      if (REG_ADDR_I == self_diag_pkg::STATUS_REG_ADDR)
      begin
        state_next.ack = 1'b1;
        if (!REG_WE_I)
        begin
          state_next.rdata = state_reg.status;
        end
        else
        begin
          // Writes acknowledged but discarded
          state_next.rdata = state_reg.rdata;
        end
      end
      else
      begin
        state_next.exc = 1'b1;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_reg.op_state <= self_diag_pkg::ST_NORMAL;
      state_reg.recov_cnt <= '0;
      state_reg.recov_expired <= 1'b0;
      state_reg.blink_cnt <= '0;
      state_reg.blink <= 1'b0;
      state_reg.status <= self_diag_pkg::STATUS_RESET;
      state_reg.rdata <= 16'h0000;
      state_reg.ack <= 1'b0;
      state_reg.exc <= 1'b0;
      state_reg.relays <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Indication decode per operating state
  // ************************************************************
  always_comb
  begin
    ready = 1'b0;
    led_blink_en = 1'b1;
    beep = 1'b0;
    hmi_fault = 1'b0;
    blocked = 1'b1;
    case (state_reg.op_state)
      self_diag_pkg::ST_NORMAL:
      begin
        ready = 1'b1;
        led_blink_en = 1'b0;
        beep = 1'b0;
        hmi_fault = 1'b0;
        blocked = 1'b0;
      end
      self_diag_pkg::ST_ERROR:
      begin
        ready = 1'b0;
        led_blink_en = 1'b1;
        beep = 1'b1;
        hmi_fault = 1'b1;
        blocked = 1'b1;
      end
      self_diag_pkg::ST_CONFIRMED:
      begin
        ready = 1'b0;
        led_blink_en = 1'b1;
        beep = 1'b0;
        hmi_fault = 1'b0;
        blocked = 1'b1;
      end
      default:
      begin
        // Unknown state fails safe: blocked and silent
        ready = 1'b0;
        led_blink_en = 1'b1;
        beep = 1'b0;
        hmi_fault = 1'b0;
        blocked = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign READY_LED_O = ready | (led_blink_en & state_reg.blink);
  assign READY_RELAY_O = ready;
  assign BEEPER_O = beep;
  assign HMI_FAULT_O = hmi_fault;
  assign OP_STATE_O = state_reg.op_state;
  assign FAULT_STATUS_O = state_reg.status;
  assign PROT_BLOCK_O = blocked;
  assign RELAY_BLOCK_O = blocked;
  assign RELAY_O = state_reg.relays;
  assign REG_RDATA_O = state_reg.rdata;
  assign REG_ACK_O = state_reg.ack;
  assign REG_EXC_O = state_reg.exc;

endmodule : self_diagnostic_monitor

// file: verification/self_diag_props.sv
// Port checker for the self-diagnostic supervisor
`timescale 1ns/10ps
module self_diag_props #(
  parameter int unsigned BLINK_HALF_CYCLES = 4
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // Requests
  input wire logic [self_diag_pkg::HW_FAULT_W-1:0] HW_FAULT_I,
  input wire logic FAULT_ACK_I,
  input wire logic REG_SEL_I,
  input wire logic REG_WE_I,
  input wire logic [15:0] REG_ADDR_I,
  // Answers
  input wire logic [15:0] REG_RDATA_O,
  input wire logic REG_ACK_O,
  input wire logic REG_EXC_O,
  input wire logic READY_LED_O,
  input wire logic READY_RELAY_O,
  input wire logic BEEPER_O,
  input wire logic HMI_FAULT_O,
  input wire logic [1:0] OP_STATE_O,
  input wire logic [15:0] FAULT_STATUS_O,
  input wire logic PROT_BLOCK_O,
  input wire logic RELAY_BLOCK_O
);
  // ************************************************************
  // Properties
  // ************************************************************
  localparam int BLK = BLINK_HALF_CYCLES + 1;
  logic hit;
  assign hit = REG_SEL_I && (REG_ADDR_I == self_diag_pkg::STATUS_REG_ADDR);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  normal_outputs_a: assert property (
    OP_STATE_O == 2'h0 |-> READY_LED_O && READY_RELAY_O && !PROT_BLOCK_O && !RELAY_BLOCK_O)
    else $error("normal state indications wrong");
  fault_blocks_a: assert property (
    OP_STATE_O != 2'h0 |-> PROT_BLOCK_O && RELAY_BLOCK_O && !READY_RELAY_O)
    else $error("blocking missing outside normal");
  beep_error_a: assert property (
    (BEEPER_O && HMI_FAULT_O) == (OP_STATE_O == 2'h1) && BEEPER_O == HMI_FAULT_O)
    else $error("beeper or display wrong");
  three_states_a: assert property (OP_STATE_O != 2'h3)
    else $error("illegal operating state");
  unused_zero_a: assert property (
    (FAULT_STATUS_O & ~self_diag_pkg::STATUS_USED_MASK) == 16'h0000)
    else $error("unassigned status bit set");
  hw_map_a: assert property (
    $past(RST_N_I) |-> FAULT_STATUS_O[7:0] == $past(HW_FAULT_I[7:0]))
    else $error("hardware bits misplaced");
  board_map_a: assert property (
    $past(RST_N_I) |-> {FAULT_STATUS_O[12], FAULT_STATUS_O[9:8]} == $past(HW_FAULT_I[10:8]))
    else $error("board bits misplaced");
  fault_entry_a: assert property (
    OP_STATE_O == 2'h0 && FAULT_STATUS_O != 16'h0000 |=> OP_STATE_O == 2'h1)
    else $error("fault did not enter error");
  ack_confirm_a: assert property (
    OP_STATE_O == 2'h1 && FAULT_ACK_I && FAULT_STATUS_O != 16'h0000 |=> OP_STATE_O == 2'h2)
    else $error("acknowledge not confirmed");
  read_data_a: assert property (
    hit && !REG_WE_I |=> REG_ACK_O && !REG_EXC_O && REG_RDATA_O == $past(FAULT_STATUS_O))
    else $error("status read wrong");
  write_ignored_a: assert property (hit && REG_WE_I |=> REG_ACK_O && $stable(REG_RDATA_O))
    else $error("write changed read data");
  unmapped_exc_a: assert property (REG_SEL_I && !hit |=> REG_EXC_O && !REG_ACK_O)
    else $error("unmapped access not refused");
  led_blink_a: assert property (
    OP_STATE_O != 2'h0 |-> ##[1:BLK] ($changed(READY_LED_O) || OP_STATE_O == 2'h0))
    else $error("ready LED not blinking");
endmodule : self_diag_props

bind self_diagnostic_monitor self_diag_props #(
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) self_diag_props_i (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .HW_FAULT_I(HW_FAULT_I), .FAULT_ACK_I(FAULT_ACK_I),
  .REG_SEL_I(REG_SEL_I), .REG_WE_I(REG_WE_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O), .REG_EXC_O(REG_EXC_O),
  .READY_LED_O(READY_LED_O), .READY_RELAY_O(READY_RELAY_O), .BEEPER_O(BEEPER_O),
  .HMI_FAULT_O(HMI_FAULT_O), .OP_STATE_O(OP_STATE_O), .FAULT_STATUS_O(FAULT_STATUS_O),
  .PROT_BLOCK_O(PROT_BLOCK_O), .RELAY_BLOCK_O(RELAY_BLOCK_O)
);

// file: verification/modbus_master_model.sv
// Supervisory register master seen from the device's register port
`timescale 1ns/10ps
module modbus_master_model (
  // Clock
  input wire logic clk_i,
  // Request
  output logic sel_o,
  output logic we_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o,
  // Answer
  input wire logic [15:0] rdata_i,
  input wire logic ack_i,
  input wire logic exc_i
);
  initial
  begin
    sel_o = 1'b0;
    we_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  // One-cycle strobe, answer taken the cycle after
  task automatic access(input logic we, input logic [15:0] addr, input logic [15:0] wd,
    output logic [15:0] rd, output logic [1:0] ans);
    @(posedge clk_i);
    sel_o <= 1'b1;
    we_o <= we;
    addr_o <= addr;
    wdata_o <= wd;
    @(posedge clk_i);
    // Released lines show the inverse, never a stale value
    sel_o <= 1'b0;
    we_o <= ~we;
    addr_o <= ~addr;
    wdata_o <= ~wd;
    @(negedge clk_i);
    rd = rdata_i;
    ans = {ack_i, exc_i};
  endtask : access
endmodule : modbus_master_model

// file: verification/self_diagnostic_monitor_tb.sv
// Self-checking bench for the self-diagnostic supervisor
`timescale 1ns/10ps
module self_diagnostic_monitor_tb;
  // ************************************************************
  // Stimulus, design and checks
  // ************************************************************
  localparam logic [15:0] SA = self_diag_pkg::STATUS_REG_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [10:0] hw = 11'h000;
  logic hb_rt = 1'b0;
  logic hb_bg = 1'b0;
  logic [1:0] hb_en = 2'h3;
  logic [1:0] hb_div = 2'h0;
  logic ack = 1'b0;
  logic map = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic sel, we, led, rly, bp, hmi, pb, rb, r_ack, r_exc;
  logic [15:0] addr, wd, r_data, st, ind, rd;
  logic [1:0] op, ans;
  logic [7:0] rel;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  assign ind = {9'h000, rly, bp, hmi, pb, rb, op};
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    hb_div <= hb_div + 2'h1;
    if (hb_div == 2'h0 && hb_en[0]) hb_rt <= ~hb_rt;
    if (hb_div == 2'h0 && hb_en[1]) hb_bg <= ~hb_bg;
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count = err_count + 1;
      tally_and_finish();
    end
  end
  self_diagnostic_monitor #(.RECOVERY_CYCLES(50), .BLINK_HALF_CYCLES(4), .HEARTBEAT_CYCLES(20))
  self_diagnostic_monitor_i (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .HW_FAULT_I(hw), .REALTIME_SOFTWARE_MODULE_HB_I(hb_rt),
    .BACKGROUND_SOFTWARE_MODULE_HB_I(hb_bg), .FAULT_ACK_I(ack), .READY_MAP_DO6_I(map),
    .RELAY_CMD_I(cmd), .REG_SEL_I(sel), .REG_WE_I(we), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
    .REG_RDATA_O(r_data), .REG_ACK_O(r_ack), .REG_EXC_O(r_exc), .READY_LED_O(led),
    .READY_RELAY_O(rly), .BEEPER_O(bp), .HMI_FAULT_O(hmi), .OP_STATE_O(op),
    .FAULT_STATUS_O(st), .PROT_BLOCK_O(pb), .RELAY_BLOCK_O(rb), .RELAY_O(rel));
  modbus_master_model modbus_master_model_i (.clk_i(clk), .sel_o(sel), .we_o(we),
    .addr_o(addr), .wdata_o(wd), .rdata_i(r_data), .ack_i(r_ack), .exc_i(r_exc));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : w
  task automatic t_reset;
    chk(ind, 16'h0040);
    chk({15'h0000, led}, 16'h0001);
    modbus_master_model_i.access(1'b1, SA, 16'hFFFF, rd, ans);
    chk({14'h0000, ans}, 16'h0002);
    chk(rd, 16'h0000);
    modbus_master_model_i.access(1'b0, SA, 16'h0000, rd, ans);
    chk(rd, 16'h0000);
    modbus_master_model_i.access(1'b0, SA + 16'h0001, 16'h0000, rd, ans);
    chk({14'h0000, ans}, 16'h0001);
  endtask : t_reset
  task automatic t_map;
    int pos;
    for (int i = 0; i < 11; i++)
    begin
      pos = (i == 10) ? 12 : i;
      @(posedge clk);
      hw <= 11'h001 << i;
      w(2);
      chk(st, 16'h0001 << pos);
      chk(ind, 16'h003D);
      modbus_master_model_i.access(1'b0, SA, 16'h0000, rd, ans);
      chk(rd, 16'h0001 << pos);
      @(posedge clk);
      hw <= 11'h000;
      w(3);
      chk(ind, 16'h0040);
    end
  endtask : t_map
  task automatic t_soft;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      hb_en <= (k == 0) ? 2'h2 : 2'h1;
      w(30);
      chk(st, (k == 0) ? 16'h2000 : 16'h4000);
      @(posedge clk);
      hb_en <= 2'h3;
      w(8);
      chk(ind, 16'h0040);
    end
  endtask : t_soft
  task automatic t_ack;
    logic [1:0] seen;
    seen = 2'h0;
    @(posedge clk);
    ack <= 1'b1;
    w(2);
    chk(ind, 16'h0040);
    @(posedge clk);
    ack <= 1'b0;
    hw <= 11'h004;
    w(60);
    chk(ind, 16'h003D);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    w(1);
    chk(ind, 16'h000E);
    repeat (10)
    begin
      @(negedge clk);
      if (led === 1'b1) seen[1] = 1'b1;
      if (led === 1'b0) seen[0] = 1'b1;
    end
    chk({14'h0000, seen}, 16'h0003);
    @(posedge clk);
    hw <= 11'h000;
    w(3);
    chk(ind, 16'h0040);
  endtask : t_ack
  task automatic t_restart;
    repeat (2)
    begin
      @(posedge clk);
      hw <= 11'h080;
      w(30);
      @(posedge clk);
      hw <= 11'h000;
      w(4);
      chk(ind, 16'h0040);
    end
    @(posedge clk);
    hw <= 11'h080;
    w(60);
    @(posedge clk);
    hw <= 11'h000;
    w(3);
    chk(ind, 16'h003D);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    w(2);
    chk(ind, 16'h0040);
  endtask : t_restart
  task automatic t_relay;
    @(posedge clk);
    cmd <= 8'h0F;
    w(2);
    chk({8'h00, rel}, 16'h000F);
    @(posedge clk);
    map <= 1'b1;
    w(2);
    chk({8'h00, rel}, 16'h002F);
    @(posedge clk);
    hw <= 11'h400;
    w(3);
    chk({8'h00, rel}, 16'h0000);
    @(posedge clk);
    hw <= 11'h000;
    w(4);
    chk({8'h00, rel}, 16'h002F);
  endtask : t_relay
  task automatic tally_and_finish;
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    w(1);
    t_reset();
    t_map();
    t_soft();
    t_ack();
    t_restart();
    t_relay();
    tally_and_finish();
  end
endmodule : self_diagnostic_monitor_tb
